// ### shared/ofc_pkg.sv
// constants and carriers for the payload fec chain
package ofc_pkg;
   // ==========================================
   // sizes and counts
   localparam int PAD_BLOCK = 1792;  // pad granule
   localparam int ILV_BITS  = 8064;  // outer block
   localparam int ILV_DEPTH = 4;     // rs depth
   localparam int ILV_PW    = 13;    // log2 of P
   localparam int GRP_BITS  = 48;    // mux cycle
   localparam int GRP_EQ    = 6;     // equal group
   localparam int GRP_HI    = 7;     // 4/7 group
   localparam int GRP_LO    = 5;     // 4/5 group
   // ==========================================
   // header field values
   localparam logic       REV_BIT  = 1'b0;
   localparam logic [1:0] CP_FIELD = 2'b10;
   // ==========================================
   // mother code taps, din is msb
   localparam logic [6:0] POLY0 = 7'h5b;  // 133 oct
   localparam logic [6:0] POLY1 = 7'h79;  // 171 oct
   localparam logic [6:0] POLY2 = 7'h75;  // 165 oct
   // keep masks, 3 bits per phase
   localparam logic [11:0] PUN_47 = 12'h2cf;
   localparam logic [11:0] PUN_23 = 12'h24f;
   localparam logic [11:0] PUN_45 = 12'h24b;
   // ==========================================
   // rate modes
   typedef enum logic [2:0] {
      M_A14 = 3'h0, M_A15 = 3'h1, M_A16 = 3'h2,
      M_A17 = 3'h3, M_A18 = 3'h4, M_A19 = 3'h5,
      M_A20 = 3'h6, M_A21 = 3'h7
   } ofc_mode_e;
   // one bit with frame end mark
   typedef struct packed {
      logic data;
      logic last;
   } ofc_bit_s;
   // muxed bit towards the mapper
   typedef struct packed {
      logic       data;
      logic       last;
      logic [2:0] symBits;
   } ofc_out_s;
endpackage : ofc_pkg

// ### rtl/ofc_conv_punct.sv
// rate 1/3 k=7 encoder with puncturing
`timescale 1ns/1ps
module ofc_conv_punct (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // control
   input  wire logic        clr,
   input  wire logic        step,
   input  wire logic        din,
   input  wire logic [11:0] keepMask,
   // punctured output
   output      logic [2:0]  keptBits,
   output      logic [1:0]  keptCnt
);
   import ofc_pkg::*;
   typedef struct packed {
      logic [5:0] sr;     // delay line
      logic [1:0] phase;  // puncture column
   } ofc_enc_s;
   ofc_enc_s s_reg, s_next;
   logic [6:0] win;
   logic [2:0] code, sel;
   // ==========================================
   // encode then drop masked bits
   always_comb begin
      win = {din, s_reg.sr};
      code = {^(win & POLY2), ^(win & POLY1), ^(win & POLY0)};
      sel = keepMask[3*s_reg.phase +: 3];
      keptBits = 3'h0;
      keptCnt = 2'h0;
      for (int i = 0; i < 3; i++) begin
         if (sel[i]) begin
            keptBits[keptCnt] = code[i];
            keptCnt = keptCnt + 2'h1;
         end
      end
      s_next = s_reg;
      if (clr) begin
         s_next = '0;
      end else if (step) begin
         s_next.sr = {din, s_reg.sr[5:1]};
         s_next.phase = s_reg.phase + 2'h1;
      end
   end
   // ==========================================
   // state register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   clr_zero_a : assert property (@(posedge mclk) disable iff (!rst_n)
      clr |=> s_reg.sr == 6'h0) else $error("delay line not cleared");
   shift_in_a : assert property (@(posedge mclk) disable iff (!rst_n)
      step && !clr |=> s_reg.sr[5] == $past(din)) else $error("input not shifted");
endmodule : ofc_conv_punct

// ### rtl/ofc_outer_ilv.sv
// pruned quadratic outer bit interleaver
`timescale 1ns/1ps
module ofc_outer_ilv #(
   parameter int N  = 8064,
   parameter int PW = 13
) (
   // clock and reset
   input  wire logic           mclk,
   input  wire logic           rst_n,
   // rs coded input
   input  ofc_pkg::ofc_bit_s   inBit,
   input  wire logic           inValid,
   output      logic           inReady,
   // interleaved output
   output ofc_pkg::ofc_bit_s   outBit,
   output      logic           outValid,
   input  wire logic           outReady
);
   import ofc_pkg::*;
   localparam logic [PW:0] P = (PW+1)'(1 << PW);
   typedef struct packed {
      logic          fill;     // writing phase
      logic [PW-1:0] wIdx;     // write address
      logic [PW:0]   sIdx;     // sequence index S
      logic [PW-1:0] tIdx;     // S(S+1)/2 mod P
      logic [PW-1:0] emitted;  // kept outputs
      logic          lastSeen; // frame end held
      logic          oValid;
      ofc_bit_s      oBit;
   } ofc_ilv_s;
   ofc_ilv_s s_reg, s_next;
   // single buffer: simple, halves throughput
   logic mem [N];
   // ==========================================
   // fill then walk the triangular sequence
   always_comb begin
      s_next = s_reg;
      if (s_reg.fill) begin
         if (inValid) begin
            s_next.wIdx = s_reg.wIdx + 1'b1;
            s_next.lastSeen = s_reg.lastSeen | inBit.last;
            if (s_reg.wIdx == PW'(N-1)) begin
               s_next.fill = 1'b0;
               s_next.sIdx = '0;
               s_next.tIdx = '0;
               s_next.emitted = '0;
            end
         end
      end else if (!s_reg.oValid || outReady) begin
         s_next.oValid = 1'b0;
         if (s_reg.sIdx < P) begin
            // indices past the block are pruned
            if (s_reg.tIdx < PW'(N)) begin
               s_next.oValid = 1'b1;
               s_next.oBit.data = mem[s_reg.tIdx];
               s_next.oBit.last = s_reg.lastSeen && (s_reg.emitted == PW'(N-1));
               s_next.emitted = s_reg.emitted + 1'b1;
            end
            s_next.tIdx = PW'(s_reg.tIdx + s_reg.sIdx[PW-1:0] + 1'b1);
            s_next.sIdx = s_reg.sIdx + 1'b1;
         end else begin
            s_next.fill = 1'b1;
            s_next.wIdx = '0;
            s_next.lastSeen = 1'b0;
         end
      end
   end
   assign inReady = s_reg.fill;
   assign outValid = s_reg.oValid;
   assign outBit = s_reg.oBit;
   // ==========================================
   // state and block store
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{fill: 1'b1, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end
   always_ff @(posedge mclk) begin
      if (s_reg.fill && inValid) begin
         mem[s_reg.wIdx] <= inBit.data;
      end
   end
   blk_size_a : assert property (@(posedge mclk) disable iff (!rst_n)
      inValid && inReady && s_reg.wIdx == PW'(N-1) |=> !inReady) else $error("block size wrong");
   prune_a : assert property (@(posedge mclk) disable iff (!rst_n)
      !s_reg.fill && (!s_reg.oValid || outReady) && s_reg.sIdx < P && s_reg.tIdx >= PW'(N)
      |=> !outValid) else $error("pruned index emitted");
endmodule : ofc_outer_ilv

// ### rtl/ofc_fec_chain.sv
// payload fec chain: outer interleave, encode, puncture, mux
// ==========================================
// What this block does
// - bit reversal header bit sent as zero
// - prefix length field set to 10
// - requested prefix length field set to 10
// - pad count to next 1792 multiple
// - fixed chain order through outer coding stages
// - outer interleaver blocks of 8064, depth 4
// - triangular order mod P, pruned past block
// - upper bits 4n+3,4n+2,4n+1 to A,B,C
// - lower bits 4n+3..4n to E..H
// - rate 1/3, K=7, octal 133/171/165
// - encoder delay cleared each frame
// - puncture to 4/7, 2/3, 4/5
// - last block punctured only where filled
// - mux and interleave chosen by mode
// - upper-branch-only mode uses A to D
// - A-D upper branch, E-H lower branch
// - muxed bits go on to symbol mapping
// - equal mode: six bits per encoder
// - coding mode: A-D 4/7, E-H 4/5
// - 48-bit group interleave permutation
`timescale 1ns/1ps
module ofc_fec_chain (
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_n,
   // frame control
   input  wire logic          frameStart,
   input  ofc_pkg::ofc_mode_e mode,
   input  wire logic [19:0]   payloadBits,
   // header fields and pad count
   output      logic          bitReversal,
   output      logic [1:0]    prefixLenField,
   output      logic [1:0]    requestedPrefixLenField,
   output      logic [10:0]   padBits,
   // upper rs branch
   input  ofc_pkg::ofc_bit_s  upBit,
   input  wire logic          upValid,
   output      logic          upReady,
   // lower rs branch
   input  ofc_pkg::ofc_bit_s  loBit,
   input  wire logic          loValid,
   output      logic          loReady,
   // to constellation mapper
   output ofc_pkg::ofc_out_s  outBit,
   output      logic          outValid,
   input  wire logic          outReady
);
   import ofc_pkg::*;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_RUN   = 3'b010,
      ST_FLUSH = 3'b100
   } ofc_state_e;
   typedef struct packed {
      ofc_state_e       st;
      ofc_mode_e        mode;
      logic             rev;       // header bit
      logic [1:0]       cpLen;     // header field
      logic [1:0]       reqCpLen;  // header field
      logic [10:0]      pad;       // zero pad count
      logic [3:0]       nibU;      // upper demux
      logic [1:0]       cntU;
      logic             fullU;
      logic [3:0]       nibL;      // lower demux
      logic [1:0]       cntL;
      logic             fullL;
      logic             endU;      // last bit taken
      logic             clr;       // encoder clear
      logic [7:0][9:0]  bufs;      // punctured bits
      logic [7:0][3:0]  cnts;
      logic [47:0]      blkD;      // interleaved group
      logic [47:0]      blkM;      // valid positions
      logic             blkFin;    // final group
      logic             busy;      // serialising
      logic [5:0]       pos;
      logic             oValid;
      ofc_out_s         oBit;
   } ofc_core_s;
   ofc_core_s s_reg, s_next;
   // ==========================================
   // helpers
   // group size per encoder and mode
   function automatic logic [3:0] grpSize(ofc_mode_e m, int e);
      if (m == M_A17 || m == M_A18) begin
         grpSize = (e < 4) ? 4'(GRP_HI) : 4'(GRP_LO);
      end else if (m == M_A21 && e >= 4) begin
         grpSize = 4'h0;
      end else begin
         grpSize = 4'(GRP_EQ);
      end
   endfunction : grpSize
   // puncture pattern per encoder and mode
   function automatic logic [11:0] punMask(ofc_mode_e m, int e);
      case (m)
         M_A14: punMask = PUN_47;
         M_A16, M_A20: punMask = PUN_45;
         M_A17, M_A18: punMask = (e < 4) ? PUN_47 : PUN_45;
         default: punMask = PUN_23;
      endcase
   endfunction : punMask
   // 48-bit group permutation
   function automatic logic [5:0] ilvIdx(ofc_mode_e m, int x);
      int v;
      v = 6 * (x / 6) - 5 * (x % 6) + 48;
      if (m == M_A19 || m == M_A20) begin
         ilvIdx = 6'(2 * (v % 24) + ((x >= 24) ? 1 : 0));
      end else begin
         ilvIdx = 6'(v % 48);
      end
   endfunction : ilvIdx
   // ==========================================
   // outer interleavers, one per rs branch
   ofc_bit_s ilvUBit, ilvLBit;
   logic     ilvUValid, ilvLValid;
   logic     takeU, takeL;
   ofc_outer_ilv #(.N(ILV_BITS), .PW(ILV_PW)) u_ilv_up (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .inBit    (upBit),
      .inValid  (upValid),
      .inReady  (upReady),
      .outBit   (ilvUBit),
      .outValid (ilvUValid),
      .outReady (!s_reg.fullU && s_reg.st == ST_RUN)
   );
   ofc_outer_ilv #(.N(ILV_BITS), .PW(ILV_PW)) u_ilv_lo (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .inBit    (loBit),
      .inValid  (loValid),
      .inReady  (loReady),
      .outBit   (ilvLBit),
      .outValid (ilvLValid),
      .outReady (!s_reg.fullL && s_reg.st == ST_RUN)
   );
   assign takeU = ilvUValid && !s_reg.fullU && s_reg.st == ST_RUN;
   assign takeL = ilvLValid && !s_reg.fullL && s_reg.st == ST_RUN;
   // ==========================================
   // eight encoders, A-D upper, E-H lower
   logic            stepU, stepL, loadBlk, roomOk, grpOk, bufsEmpty, drained;
   logic [7:0]      encStep, encDin;
   logic [7:0][2:0] keptBits;
   logic [7:0][1:0] keptCnt;
   always_comb begin
      for (int e = 0; e < 8; e++) begin
         encStep[e] = (e < 4) ? stepU : stepL;
         encDin[e] = (e < 4) ? s_reg.nibU[e % 4] : s_reg.nibL[e % 4];
      end
   end
   for (genvar e = 0; e < 8; e++) begin : g_enc
      ofc_conv_punct u_enc (
         .mclk     (mclk),
         .rst_n    (rst_n),
         .clr      (s_reg.clr),
         .step     (encStep[e]),
         .din      (encDin[e]),
         .keepMask (punMask(s_reg.mode, e)),
         .keptBits (keptBits[e]),
         .keptCnt  (keptCnt[e])
      );
   end
   // ==========================================
   // step, group and load decisions
   always_comb begin
      roomOk = 1'b1;
      grpOk = 1'b1;
      bufsEmpty = 1'b1;
      for (int e = 0; e < 8; e++) begin
         // room for three more bits of a step
         if (s_reg.cnts[e] > 4'h7) roomOk = 1'b0;
         if (s_reg.cnts[e] < grpSize(s_reg.mode, e)) grpOk = 1'b0;
         if (s_reg.cnts[e] != 4'h0) bufsEmpty = 1'b0;
      end
      // stream over: last bit taken and its nibble encoded
      drained = s_reg.endU && !s_reg.fullU && s_reg.cntU == 2'h0;
      // a load owns the buffers this cycle
      loadBlk = !s_reg.busy && ((s_reg.st == ST_RUN && grpOk)
                || (s_reg.st == ST_FLUSH && !bufsEmpty));
      stepU = s_reg.st == ST_RUN && !loadBlk && roomOk && s_reg.fullU
              && (s_reg.mode == M_A21 || s_reg.fullL);
      stepL = stepU && s_reg.mode != M_A21;
   end
   // ==========================================
   // next state
   always_comb begin
      logic [47:0] rawD, rawM;
      int          p;
      logic [3:0]  g;
      logic [5:0]  y;
      rawD = '0;
      rawM = '0;
      p = 0;
      g = 4'h0;
      y = 6'h0;
      s_next = s_reg;
      s_next.clr = 1'b0;
      // frame start: fields, pad, clear
      if (s_reg.st == ST_IDLE && frameStart) begin
         s_next = '0;
         s_next.st = ST_RUN;
         s_next.mode = mode;
         s_next.clr = 1'b1;
         s_next.rev = REV_BIT;
         s_next.cpLen = CP_FIELD;
         s_next.reqCpLen = CP_FIELD;
         // a bit still waiting for the mapper must stand until taken
         s_next.oValid = s_reg.oValid;
         s_next.oBit = s_reg.oBit;
         if (payloadBits % PAD_BLOCK == 0) begin
            s_next.pad = 11'h0;
         end else begin
            s_next.pad = 11'(PAD_BLOCK - payloadBits % PAD_BLOCK);
         end
      end
      // upper demux: bit k to encoder 3-(k mod 4)
      if (takeU) begin
         s_next.nibU[3 - s_reg.cntU] = ilvUBit.data;
         s_next.cntU = s_reg.cntU + 2'h1;
         s_next.fullU = s_reg.cntU == 2'h3;
         s_next.endU = s_reg.endU | ilvUBit.last;
      end
      // lower demux, same dealing
      if (takeL) begin
         s_next.nibL[3 - s_reg.cntL] = ilvLBit.data;
         s_next.cntL = s_reg.cntL + 2'h1;
         s_next.fullL = s_reg.cntL == 2'h3;
      end
      if (stepU) begin
         s_next.fullU = 1'b0;
         s_next.fullL = 1'b0;
         // append punctured bits per encoder
         for (int e = 0; e < 8; e++) begin
            if (encStep[e]) begin
               s_next.bufs[e] = s_reg.bufs[e] | (10'(keptBits[e]) << s_reg.cnts[e]);
               s_next.cnts[e] = s_reg.cnts[e] + 4'(keptCnt[e]);
            end
         end
      end
      // upper stream done: drain what is left
      if (s_reg.st == ST_RUN && drained) begin
         s_next.st = ST_FLUSH;
      end
      // group mux then 48-bit interleave
      if (loadBlk) begin
         for (int e = 0; e < 8; e++) begin
            g = grpSize(s_reg.mode, e);
            for (int j = 0; j < GRP_HI; j++) begin
               if (4'(j) < g) begin
                  rawD[p] = s_reg.bufs[e][j];
                  rawM[p] = 4'(j) < s_reg.cnts[e];
                  p = p + 1;
               end
            end
            s_next.bufs[e] = s_reg.bufs[e] >> g;
            s_next.cnts[e] = (s_reg.cnts[e] > g) ? s_reg.cnts[e] - g : 4'h0;
         end
         for (int x = 0; x < GRP_BITS; x++) begin
            y = ilvIdx(s_reg.mode, x);
            s_next.blkD[y] = rawD[x];
            s_next.blkM[y] = rawM[x];
         end
         // a load that empties the buffers after the stream ended is final, even before flush
         s_next.blkFin = drained && s_next.cnts == '0;
         s_next.busy = 1'b1;
         s_next.pos = 6'h0;
      end
      // serialise, skipping unfilled positions
      if (!s_reg.oValid || outReady) begin
         s_next.oValid = 1'b0;
         if (s_reg.busy) begin
            s_next.oValid = s_reg.blkM[s_reg.pos];
            s_next.oBit.data = s_reg.blkD[s_reg.pos];
            s_next.oBit.last = s_reg.blkFin && (s_reg.blkM >> s_reg.pos) == 48'h1;
            // modes A19 and A20 map to 16-qam, else qpsk
            s_next.oBit.symBits = (s_reg.mode == M_A19 || s_reg.mode == M_A20)
                                  ? 3'h4 : 3'h2;
            s_next.pos = s_reg.pos + 6'h1;
            if (s_reg.pos == 6'(GRP_BITS - 1)) begin
               s_next.busy = 1'b0;
               if (s_reg.blkFin) s_next.st = ST_IDLE;
            end
         end
      end
   end
   // ==========================================
   // state register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{st: ST_IDLE, mode: M_A14, rev: REV_BIT, cpLen: CP_FIELD,
                    reqCpLen: CP_FIELD, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end
   // ==========================================
   // outputs, all from flip-flops
   assign bitReversal = s_reg.rev;
   assign prefixLenField = s_reg.cpLen;
   assign requestedPrefixLenField = s_reg.reqCpLen;
   assign padBits = s_reg.pad;
   assign outBit = s_reg.oBit;
   assign outValid = s_reg.oValid;
   // ==========================================
   // checks
   hdr_rev_a : assert property (@(posedge mclk) disable iff (!rst_n)
      frameStart && s_reg.st == ST_IDLE |=> bitReversal == 1'b0) else $error("reversal bit set");
   cp_len_a : assert property (@(posedge mclk) disable iff (!rst_n)
      frameStart && s_reg.st == ST_IDLE |=> prefixLenField == 2'b10) else $error("prefix field bad");
   req_cp_a : assert property (@(posedge mclk) disable iff (!rst_n)
      frameStart |=> requestedPrefixLenField == 2'b10) else $error("requested field bad");
   pad_len_a : assert property (@(posedge mclk) disable iff (!rst_n)
      frameStart && s_reg.st == ST_IDLE |=> (padBits + $past(payloadBits)) % 1792 == 0
      && padBits < 11'd1792) else $error("pad count wrong");
   demux_up_a : assert property (@(posedge mclk) disable iff (!rst_n)
      takeU && s_reg.cntU == 2'h0 |=> s_reg.nibU[3] == $past(ilvUBit.data)) else $error("upper deal wrong");
   upper_only_a : assert property (@(posedge mclk) disable iff (!rst_n)
      s_reg.mode == M_A21 |-> !stepL) else $error("lower branch stepped");
   clr_start_a : assert property (@(posedge mclk) disable iff (!rst_n)
      frameStart && s_reg.st == ST_IDLE |=> s_reg.clr ##1 !s_reg.clr) else $error("no frame clear");
   // ==========================================
   // stream, flush and mapper side checks
   demux_lo_a : assert property (@(posedge mclk) disable iff (!rst_n)
      takeL && s_reg.cntL == 2'h0 |=> s_reg.nibL[3] == $past(ilvLBit.data)) else $error("lower deal wrong");
   // an idle flush with empty buffers would never mark the frame end
   flush_live_a : assert property (@(posedge mclk) disable iff (!rst_n)
      s_reg.st == ST_FLUSH && !s_reg.busy |-> !bufsEmpty) else $error("flush has nothing to send");
   grp_size_a : assert property (@(posedge mclk) disable iff (!rst_n)
      loadBlk && s_reg.st == ST_RUN && (s_reg.mode == M_A17 || s_reg.mode == M_A18)
      |-> s_reg.cnts[0] >= 4'h7 && s_reg.cnts[4] >= 4'h5) else $error("uneven group short");
   // three bits per step must always fit the ten-bit buffers of A and E
   buf_room_a : assert property (@(posedge mclk) disable iff (!rst_n)
      s_reg.cnts[0] <= 4'ha && s_reg.cnts[4] <= 4'ha) else $error("puncture buffer overflow");
   lo_idle_a : assert property (@(posedge mclk) disable iff (!rst_n)
      s_reg.mode == M_A21 |-> s_reg.cnts[4] == 4'h0 && s_reg.cnts[7] == 4'h0) else $error("lower encoders used");
   sym_bits_a : assert property (@(posedge mclk) disable iff (!rst_n)
      outValid && s_reg.busy && (s_reg.mode == M_A14 || s_reg.mode == M_A21) |-> outBit.symBits == 3'h2)
      else $error("symbol width wrong");
   // the mapper may stall; nothing it has not taken may change
   out_hold_a : assert property (@(posedge mclk) disable iff (!rst_n)
      outValid && !outReady |=> outValid && $stable(outBit)) else $error("output dropped while stalled");
endmodule : ofc_fec_chain

// ### bench/ofc_far_end.sv
// far end model: rs source for both branches and a stalling mapper
`timescale 1ns/1ps
module ofc_far_end (
   // clock and start
   input  wire logic         mclk,
   input  wire logic         go,
   input  wire logic         allOnes,
   input  wire logic         useLower,
   // rs side
   output ofc_pkg::ofc_bit_s upBit,
   output      logic         upValid,
   input  wire logic         upReady,
   output ofc_pkg::ofc_bit_s loBit,
   output      logic         loValid,
   input  wire logic         loReady,
   // mapper side
   output      logic         outReady
);
   import ofc_pkg::*;
   // ==========================================
   // progress through one block per branch
   int   upIdx  = ILV_BITS;  // ILV_BITS means idle
   int   loIdx  = ILV_BITS;
   int   tick   = 0;
   logic upTook = 0;
   logic loTook = 0;
   logic goSeen = 0;        // go seen on an edge, avoids a race
   initial begin
      upValid = 0; loValid = 0; outReady = 1; upBit = '0; loBit = '0;
   end
   // note what the last edge took
   always @(posedge mclk) begin
      upTook <= upValid && upReady;
      loTook <= loValid && loReady;
      goSeen <= go;
   end
   // change only after an edge; idle data toggles so stale bits never look held
   always @(negedge mclk) begin
      tick++;
      if (goSeen) begin
         upIdx = 0;
         loIdx = useLower ? 0 : ILV_BITS;
      end else begin
         if (upTook) upIdx++;
         if (loTook) loIdx++;
      end
      upValid    = upIdx < ILV_BITS;  // one whole block, bits back to back
      loValid    = loIdx < ILV_BITS;
      upBit.data = upValid ? (allOnes || upIdx == 0) : tick[0];
      upBit.last = upIdx == ILV_BITS - 1;
      loBit.data = loValid ? 1'b0 : tick[0];
      loBit.last = 1'b0;             // lower ends with the upper one
      outReady   = (tick % 8) != 7;  // mapper stalls one cycle in eight
   end
endmodule : ofc_far_end

// ### bench/ofc_fec_chain_bench.sv
// self-checking bench for the payload fec chain
`timescale 1ns/1ps
module ofc_fec_chain_bench;
   import ofc_pkg::*;
   // ==========================================
   // stimulus and observed signals
   logic        mclk = 0, rst_n = 0, frameStart = 0, go = 0, allOnes = 0, useLower = 0;
   ofc_mode_e   mode = M_A14;
   logic [19:0] payloadBits = '0;
   logic        bitReversal, upReady, loReady, upValid, loValid, outValid, outReady;
   logic [1:0]  prefixLenField, requestedPrefixLenField;
   logic [10:0] padBits;
   ofc_bit_s    upBit, loBit;
   ofc_out_s    outBit;
   int          mismatches = 0, checks = 0, beats = 0, lasts = 0, cycles = 0;
   logic [47:0] firstGrp;   // first 48 positions seen
   logic [2:0]  firstSym;
   // corner cases: payload length beside expected pad count
   typedef struct { logic [19:0] bits; logic [10:0] pad; } ofc_row_s;
   ofc_row_s rows[6] = '{'{20'h00001, 11'h6ff}, '{20'h00700, 11'h000}, '{20'h00701, 11'h6ff},
                         '{20'h00000, 11'h000}, '{20'h00e00, 11'h000}, '{20'hfffff, 11'h601}};
   always #5 mclk = ~mclk;
   // ==========================================
   // design and far end
   ofc_fec_chain ofc_fec_chain_i (.mclk(mclk), .rst_n(rst_n), .frameStart(frameStart), .mode(mode),
      .payloadBits(payloadBits), .bitReversal(bitReversal), .prefixLenField(prefixLenField),
      .requestedPrefixLenField(requestedPrefixLenField), .padBits(padBits), .upBit(upBit),
      .upValid(upValid), .upReady(upReady), .loBit(loBit), .loValid(loValid), .loReady(loReady),
      .outBit(outBit), .outValid(outValid), .outReady(outReady));
   ofc_far_end ofc_far_end_i (.mclk(mclk), .go(go), .allOnes(allOnes), .useLower(useLower),
      .upBit(upBit), .upValid(upValid), .upReady(upReady), .loBit(loBit), .loValid(loValid),
      .loReady(loReady), .outReady(outReady));
   // ==========================================
   // verdict and comparison helpers
   task automatic conclude;
      if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic check_eq(input logic [63:0] got, input logic [63:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %0h want %0h", $time, what, got, exp);
      end
   endtask : check_eq
   task automatic do_reset;
      rst_n = 0;
      repeat (10) @(negedge mclk);
      rst_n = 1;
      @(negedge mclk);
   endtask : do_reset
   // one frame: start, feed blocks, wait for the final bit
   task automatic run_frame(input ofc_mode_e m, input logic ones, input logic lower,
                            input logic [63:0] expBeats);
      beats = 0;
      lasts = 0;
      mode = m; allOnes = ones; useLower = lower; frameStart = 1; go = 1;
      @(negedge mclk);
      frameStart = 0; go = 0;
      while (lasts == 0) @(negedge mclk);
      repeat (40) @(negedge mclk);   // nothing may follow the final bit
      check_eq(beats, expBeats, "beats");
      check_eq(lasts, 1, "last count");
      check_eq(firstSym, 3'h2, "qpsk");
   endtask : run_frame
   // ==========================================
   // mapper side monitor and hang guard
   always @(posedge mclk) begin
      cycles++;
      if (outValid === 1'b1 && outReady) begin
         if (beats < 48) firstGrp[beats] = outBit.data;
         if (beats == 0) firstSym = outBit.symBits;
         beats++;
         if (outBit.last === 1'b1) lasts++;
      end
      if (cycles == 98000) begin
         mismatches++;
         conclude();
      end
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (5) @(negedge mclk);
      check_eq({outValid, upReady, loReady, padBits}, {3'h3, 11'h000}, "reset");
      check_eq({bitReversal, prefixLenField, requestedPrefixLenField}, 5'h0a, "reset hdr");
      repeat (5) @(negedge mclk);
      rst_n = 1;
      foreach (rows[i]) begin
         do_reset();
         payloadBits = rows[i].bits;
         mode = M_A16;
         frameStart = 1;
         @(negedge mclk);
         frameStart = 0;
         check_eq(padBits, rows[i].pad, "pad");
         check_eq({bitReversal, prefixLenField, requestedPrefixLenField}, 5'h0a, "hdr");
      end
      do_reset();
      // upper only, all ones: 2016 bits per encoder at 2/3 on four encoders
      run_frame(M_A21, 1'b1, 1'b0, 64'd12096);
      // one set bit at block start reaches encoder D first; state must be clear
      run_frame(M_A14, 1'b0, 1'b1, 64'd28224);
      check_eq(firstGrp, 48'h4200_0004_2100, "impulse");
      // uneven groups, seven bits from A-D and five from E-H, cut short by a reset
      beats = 0;
      mode = M_A17; allOnes = 0; useLower = 1; frameStart = 1; go = 1;
      @(negedge mclk);
      frameStart = 0; go = 0;
      while (beats < 48) @(negedge mclk);
      check_eq(firstGrp, 48'h4200_0008_4208, "uneven impulse");
      do_reset();
      check_eq({outValid, upReady, bitReversal, prefixLenField}, 5'h0a, "mid reset");
      conclude();
   end
endmodule : ofc_fec_chain_bench
